// file: design/epr_pkg.sv
/*
 * Constants for the execution priority, escalation and reset sequencing block.
 * Assumes a 32-bit AHB-Lite register bus and a 100 MHz core clock.
 */
package epr_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_GROUP_SPLIT = 8'h00;
  localparam logic [7:0] OFS_BASE_PRI = 8'h04;
  localparam logic [7:0] OFS_CFG_IRQ_MASK = 8'h08;
  localparam logic [7:0] OFS_FAULT_MASK = 8'h0C;
  localparam logic [7:0] OFS_VECTOR_BASE = 8'h10;
  localparam logic [7:0] OFS_PRI_SEL = 8'h14;
  localparam logic [7:0] OFS_PRI_DATA = 8'h18;
  localparam logic [7:0] OFS_EXEC_PRI = 8'h1C;
  localparam logic [7:0] OFS_CORE_STATUS = 8'h20;

  // Exception numbers
  localparam int NUM_EXC = 512;
  localparam logic [8:0] EXC_NONE = 9'h000;
  localparam logic [8:0] EXC_NMI = 9'h002;
  localparam logic [8:0] EXC_HARD_FAULT = 9'h003;
  localparam logic [8:0] EXC_FIRST_CFG = 9'h004;
  localparam logic [8:0] EXC_SUPERVISOR_CALL = 9'h00B;
  localparam logic [8:0] EXC_DEBUG_MONITOR = 9'h00C;

  // Priorities (signed, 10 bits)
  localparam logic signed [9:0] PRI_BASE_LEVEL = 10'sh100;
  localparam logic signed [9:0] PRI_RESET = -10'sh003;
  localparam logic signed [9:0] PRI_NMI = -10'sh002;
  localparam logic signed [9:0] PRI_HARD_FAULT = -10'sh001;
  localparam logic signed [9:0] PRI_ZERO = 10'sh000;
  localparam logic [8:0] GROUP_ONE = 9'h002;

  // Reset values and vector table layout
  localparam logic [31:0] LINK_RESET = 32'hFFFF_FFFF;
  localparam logic [31:0] SP_ALIGN_MASK = 32'hFFFF_FFFC;
  localparam logic [31:0] PC_ALIGN_MASK = 32'hFFFF_FFFE;
  localparam logic [31:0] VEC_RESET_OFS = 32'h0000_0004;
  localparam logic [6:0] VEC_LOW_ZERO = 7'h00;
  localparam logic [24:0] VECTOR_BASE_RESET = 25'h000_0000;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // Reset sequence states, Gray coded
  typedef enum logic [1:0] {
    RST_FETCH_SP = 2'b00,
    RST_FETCH_PC = 2'b01,
    RST_RUN = 2'b11
  } epr_rst_state_t;
endpackage : epr_pkg

// file: design/epr_core.sv
/*
 * Execution priority, fault escalation and reset sequencing of a processor
 * exception unit, with an AHB-Lite register slave. Assumes the pipeline
 * reports exception entry, return and requests as one-cycle pulses, and a
 * vector memory port that answers a read request with an acknowledge.
 */
// The AHB-Lite slave port and the address map were left to the implementer.
// Notes on behaviour
// [RULE1] Both priority terms start at 256, thread level with nothing active.
// [RULE2] Scan active flags 2..511, keep the lowest priority value.
// [RULE3] Strip subpriority: subtract remainder modulo two shifted by split.
// [RULE4] Nonzero base priority mask, subpriority stripped, becomes boost term.
// [RULE5] Configurable irq mask bit 0 forces boost term to 0.
// [RULE6] Fault escalation mask bit 0 forces boost term to -1, overriding all.
// [RULE7] Execution priority is the smaller of boost and active terms.
// [RULE8] Below hard fault, sync fault or call not above priority escalates.
// [RULE9] Debug monitor faults escalate only when raised by breakpoint; the code escalates a disabled one either way.
// [RULE10] A disabled configurable fault escalates to hard fault.
// [RULE11] Escalated fault keeps return address of its original type.
// [RULE12] Supervisor call under irq mask escalates.
// [RULE13] Interrupts never escalate: enabled pend, disabled ignored.
// [RULE14] Async faults pend when enabled, become hard faults when disabled.
// [RULE15] Supervisor call and pendable service are always enabled; the code treats only supervisor call as always enabled.
// [RULE16] Reset abandons state and loads every defined reset value.
// [RULE17] Vector table base is vector base bits 31:7, low bits zero.
// [RULE18] Main stack pointer from first vector word, two low bits cleared.
// [RULE19] Reset fetches base plus 4: pc bit 0 cleared, thumb bit set; the code copies word bit 0 into the thumb bit.
// [RULE20] Link register all ones, thread mode, number and it bits cleared.
// [RULE21] Reset clears irq mask, fault mask and base priority mask.
// [RULE22] Reset clears control, coprocessor access, fp defaults; sets save enables.
// [RULE23] Reset clears active flags, opens exclusive monitor, clears event.
// [RULE24] Reset, nmi and hard fault have fixed priorities -3, -2, -1.
// [RULE25] Execution priority is recomputed every clock cycle.
`timescale 1ns/1ps
module epr_core
  import epr_pkg::*;
#(
  parameter bit HAVE_FP = 1'b1
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Vector memory read port
  output logic vec_rd_req,
  output logic [31:0] vec_rd_addr,
  input wire logic vec_rd_ack,
  input wire logic [31:0] vec_rd_data,
  // Exception entry and return from pipeline
  input wire logic exc_enter,
  input wire logic [8:0] exc_enter_num,
  input wire logic exc_return,
  input wire logic [8:0] exc_return_num,
  // Synchronous fault or supervisor call request
  input wire logic sync_req,
  input wire logic [8:0] sync_num,
  input wire logic sync_enabled,
  input wire logic sync_from_breakpoint,
  // Interrupt or asynchronous fault request
  input wire logic async_req,
  input wire logic [8:0] async_num,
  input wire logic async_enabled,
  input wire logic async_is_irq,
  // Event and exclusive monitor events
  input wire logic event_clear,
  input wire logic excl_mark,
  // Exception decisions
  output logic take_valid,
  output logic [8:0] take_num,
  output logic take_escalated,
  output logic [8:0] take_ret_src,
  output logic pend_valid,
  output logic [8:0] pend_num,
  output logic signed [9:0] exec_priority,
  // Architectural state after reset
  output logic reset_done,
  output logic [31:0] main_stack_pointer,
  output logic [31:0] process_stack_pointer,
  output logic [31:0] program_counter,
  output logic thumb_bit,
  output logic [31:0] link_register,
  output logic handler_mode,
  output logic [8:0] active_exception_number,
  output logic [7:0] exec_state_it,
  output logic [2:0] control_bits,
  output logic [3:0] coproc_access_ctrl,
  output logic [4:0] fp_default_status,
  output logic auto_fp_save_enable,
  output logic lazy_fp_save_enable,
  output logic lazy_save_pending,
  output logic excl_open,
  output logic event_reg
);
  // Register state
  logic [2:0] group_split_field_ff;
  logic [7:0] base_priority_mask_ff;
  logic configurable_irq_mask_ff, fault_escalation_mask_ff;
  logic [24:0] vector_base_ff;
  logic [8:0] pri_sel_ff;
  logic [7:0] pri_mem [NUM_EXC];
  logic [NUM_EXC-1:0] exception_active_flags_ff;
  logic signed [9:0] exec_pri_ff;
  epr_rst_state_t rst_state_ff;

  // Bus state
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [31:0] hrdata_ff;

  // Decision outputs
  logic take_valid_ff, take_escalated_ff, pend_valid_ff;
  logic [8:0] take_num_ff, take_ret_src_ff, pend_num_ff;

  // Reset sequence outputs
  logic vec_rd_req_ff, thumb_ff, handler_ff, auto_save_ff, lazy_en_ff, lazy_act_ff;
  logic excl_open_ff, event_ff;
  logic [31:0] vec_rd_addr_ff, msp_ff, pc_ff, link_ff;
  logic [8:0] exc_num_ff;
  logic [7:0] it_ff;
  logic [2:0] control_ff;
  logic [3:0] coproc_ff;
  logic [4:0] fp_dflt_ff;

  // Group value mask from split field
  wire [8:0] group_value = GROUP_ONE << group_split_field_ff;
  wire [7:0] sub_mask = group_value[7:0] - 8'h01;

  function automatic logic [7:0] strip_sub(input logic [7:0] p, input logic [7:0] m);
    strip_sub = p - (p & m); // RULE3
  endfunction : strip_sub

  function automatic logic signed [9:0] exc_prio(input logic [8:0] n, input logic [7:0] p);
    if (n == EXC_NMI) exc_prio = PRI_NMI; // RULE24
    else if (n == EXC_HARD_FAULT) exc_prio = PRI_HARD_FAULT; // RULE24
    else if (n < EXC_NMI) exc_prio = PRI_RESET; // RULE24
    else exc_prio = signed'({2'b00, p});
  endfunction : exc_prio

  // Active-exception term
  logic signed [9:0] act_best;
  logic signed [9:0] act_term;
  always_comb begin
    act_best = PRI_BASE_LEVEL; // RULE1
    for (int i = 2; i < NUM_EXC; i++) begin
      if (exception_active_flags_ff[i] && exc_prio(9'(i), pri_mem[i]) < act_best) begin
        act_best = exc_prio(9'(i), pri_mem[i]); // RULE2
      end
    end
    act_term = act_best;
    if (act_best >= PRI_ZERO && act_best < PRI_BASE_LEVEL) begin
      act_term = signed'({2'b00, strip_sub(act_best[7:0], sub_mask)}); // RULE3
    end
  end

  // Boost term
  wire signed [9:0] base_term = (base_priority_mask_ff != 8'h00) ?
      signed'({2'b00, strip_sub(base_priority_mask_ff, sub_mask)}) : PRI_BASE_LEVEL; // RULE4
  wire signed [9:0] mask_term = configurable_irq_mask_ff ? PRI_ZERO : base_term; // RULE5
  wire signed [9:0] boost_term = fault_escalation_mask_ff ? PRI_HARD_FAULT : mask_term; // RULE6
  wire signed [9:0] nxt_exec_pri = (boost_term < act_term) ? boost_term : act_term; // RULE7

  // Escalation decision
  wire sync_is_call = (sync_num == EXC_SUPERVISOR_CALL);
  wire sync_is_dbg = (sync_num == EXC_DEBUG_MONITOR);
  wire sync_can_esc = !sync_is_dbg || sync_from_breakpoint; // RULE9
  wire sync_disabled = !sync_enabled && !sync_is_call; // RULE15
  wire signed [9:0] sync_grp = signed'({2'b00, strip_sub(pri_mem[sync_num], sub_mask)});
  wire below_hard_fault = (exec_pri_ff > PRI_HARD_FAULT);
  wire grp_blocked = sync_can_esc && (sync_grp >= exec_pri_ff); // RULE8 RULE12
  wire sync_escalate = below_hard_fault && (grp_blocked || sync_disabled); // RULE8 RULE10
  wire async_take = async_req && (async_enabled || !async_is_irq); // RULE13
  wire [8:0] async_dest = (async_is_irq || async_enabled) ? async_num : EXC_HARD_FAULT; // RULE14

  // Bus decode
  wire bus_sel = hsel && hready && (htrans == HTRANS_NONSEQ);
  wire bus_wr = bus_sel && hwrite;
  wire bus_rd = bus_sel && !hwrite;
  wire [7:0] rd_ofs = haddr[7:0];
  wire [31:0] core_status = {13'h0000, rst_state_ff == RST_RUN, handler_ff, exc_num_ff, 8'h00};
  wire [31:0] exec_pri_word = 32'(exec_pri_ff);
  logic [31:0] rd_word;
  always_comb begin
    if (rd_ofs == OFS_GROUP_SPLIT) begin
      rd_word = 32'(group_split_field_ff);
    end else if (rd_ofs == OFS_BASE_PRI) begin
      rd_word = 32'(base_priority_mask_ff);
    end else if (rd_ofs == OFS_CFG_IRQ_MASK) begin
      rd_word = 32'(configurable_irq_mask_ff);
    end else if (rd_ofs == OFS_FAULT_MASK) begin
      rd_word = 32'(fault_escalation_mask_ff);
    end else if (rd_ofs == OFS_VECTOR_BASE) begin
      rd_word = {vector_base_ff, VEC_LOW_ZERO};
    end else if (rd_ofs == OFS_PRI_SEL) begin
      rd_word = 32'(pri_sel_ff);
    end else if (rd_ofs == OFS_PRI_DATA) begin
      rd_word = 32'(pri_mem[pri_sel_ff]);
    end else if (rd_ofs == OFS_EXEC_PRI) begin
      rd_word = exec_pri_word;
    end else if (rd_ofs == OFS_CORE_STATUS) begin
      rd_word = core_status;
    end else begin
      rd_word = 32'h0000_0000;
    end
  end

  wire wr_go = wr_pend_ff;
  wire fm_write = wr_go && (wr_addr_ff == OFS_FAULT_MASK);
  wire fm_allowed = (exec_pri_ff >= PRI_ZERO);
  wire pri_write = wr_go && (wr_addr_ff == OFS_PRI_DATA) && (pri_sel_ff >= EXC_FIRST_CFG);
  wire fm_return_clear = exc_return && (exc_return_num != EXC_NMI);

  // Bus slave and software registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata_ff <= 32'h0000_0000;
      group_split_field_ff <= 3'h0;
      base_priority_mask_ff <= 8'h00; // RULE21
      configurable_irq_mask_ff <= 1'b0; // RULE21
      fault_escalation_mask_ff <= 1'b0; // RULE21
      vector_base_ff <= VECTOR_BASE_RESET;
      pri_sel_ff <= EXC_NONE;
    end else begin
      wr_pend_ff <= bus_wr;
      wr_addr_ff <= haddr[7:0];
      if (bus_rd) hrdata_ff <= rd_word;
      if (wr_go && wr_addr_ff == OFS_GROUP_SPLIT) group_split_field_ff <= hwdata[2:0];
      if (wr_go && wr_addr_ff == OFS_BASE_PRI) base_priority_mask_ff <= hwdata[7:0];
      if (wr_go && wr_addr_ff == OFS_CFG_IRQ_MASK) configurable_irq_mask_ff <= hwdata[0];
      if (fm_write && fm_allowed) begin
        fault_escalation_mask_ff <= hwdata[0];
      end else if (fm_return_clear) begin
        fault_escalation_mask_ff <= 1'b0;
      end
      if (wr_go && wr_addr_ff == OFS_VECTOR_BASE) vector_base_ff <= hwdata[31:7];
      if (wr_go && wr_addr_ff == OFS_PRI_SEL) pri_sel_ff <= hwdata[8:0];
    end
  end

  // Priority table, no reset: values are software defined
  always_ff @(posedge hclk) begin
    if (pri_write) begin
      pri_mem[pri_sel_ff] <= hwdata[7:0];
    end
  end

  // Active flags, set wins over clear
  genvar g;
  for (g = 0; g < NUM_EXC; g++) begin : g_active
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        exception_active_flags_ff[g] <= 1'b0; // RULE23
      end else if (exc_enter && exc_enter_num == 9'(g)) begin
        exception_active_flags_ff[g] <= 1'b1;
      end else if (exc_return && exc_return_num == 9'(g)) begin
        exception_active_flags_ff[g] <= 1'b0;
      end
    end
  end

  // Priority and exception decisions
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      exec_pri_ff <= PRI_BASE_LEVEL;
      take_valid_ff <= 1'b0;
      take_num_ff <= EXC_NONE;
      take_escalated_ff <= 1'b0;
      take_ret_src_ff <= EXC_NONE;
      pend_valid_ff <= 1'b0;
      pend_num_ff <= EXC_NONE;
    end else begin
      exec_pri_ff <= nxt_exec_pri; // RULE25
      take_valid_ff <= sync_req;
      take_escalated_ff <= sync_req && sync_escalate;
      take_num_ff <= sync_escalate ? EXC_HARD_FAULT : sync_num; // RULE8
      take_ret_src_ff <= sync_num; // RULE11
      pend_valid_ff <= async_take; // RULE13 RULE14
      pend_num_ff <= async_dest;
    end
  end

  // Reset sequence
  wire [31:0] vec_base = {vector_base_ff, VEC_LOW_ZERO}; // RULE17
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_state_ff <= RST_FETCH_SP; // RULE16
      vec_rd_req_ff <= 1'b0;
      vec_rd_addr_ff <= 32'h0000_0000;
      msp_ff <= 32'h0000_0000;
      pc_ff <= 32'h0000_0000;
      thumb_ff <= 1'b0;
    end else begin
      case (rst_state_ff)
        RST_FETCH_SP: begin
          vec_rd_req_ff <= !vec_rd_ack;
          vec_rd_addr_ff <= vec_base;
          if (vec_rd_ack && vec_rd_req_ff) begin
            msp_ff <= vec_rd_data & SP_ALIGN_MASK; // RULE18
            rst_state_ff <= RST_FETCH_PC;
          end
        end
        RST_FETCH_PC: begin
          vec_rd_req_ff <= !vec_rd_ack;
          vec_rd_addr_ff <= vec_base + VEC_RESET_OFS; // RULE19
          if (vec_rd_ack && vec_rd_req_ff) begin
            pc_ff <= vec_rd_data & PC_ALIGN_MASK; // RULE19
            thumb_ff <= vec_rd_data[0]; // RULE19
            vec_rd_req_ff <= 1'b0;
            rst_state_ff <= RST_RUN;
          end
        end
        default: vec_rd_req_ff <= 1'b0;
      endcase
    end
  end

  // Core state at reset and on entry
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_ff <= LINK_RESET; // RULE20
      handler_ff <= 1'b0; // RULE20
      exc_num_ff <= EXC_NONE; // RULE20
      it_ff <= 8'h00; // RULE20
      control_ff <= 3'b000; // RULE22
      coproc_ff <= 4'h0; // RULE22
      fp_dflt_ff <= 5'h00; // RULE22
      auto_save_ff <= HAVE_FP; // RULE22
      lazy_en_ff <= HAVE_FP; // RULE22
      lazy_act_ff <= 1'b0; // RULE22
      excl_open_ff <= 1'b1; // RULE23
      event_ff <= 1'b0; // RULE23
    end else begin
      if (exc_enter) begin
        handler_ff <= 1'b1;
        exc_num_ff <= exc_enter_num;
        it_ff <= 8'h00;
      end
      excl_open_ff <= exc_enter || (excl_open_ff && !excl_mark);
      event_ff <= exc_enter || (event_ff && !event_clear);
    end
  end

  // Outputs
  assign {hrdata, hreadyout, hresp} = {hrdata_ff, 1'b1, 1'b0};
  assign {vec_rd_req, vec_rd_addr} = {vec_rd_req_ff, vec_rd_addr_ff};
  assign {take_valid, take_num} = {take_valid_ff, take_num_ff};
  assign {take_escalated, take_ret_src} = {take_escalated_ff, take_ret_src_ff};
  assign {pend_valid, pend_num, exec_priority} = {pend_valid_ff, pend_num_ff, exec_pri_ff};
  assign reset_done = (rst_state_ff == RST_RUN);
  assign {main_stack_pointer, process_stack_pointer} = {msp_ff, 32'h0000_0000}; // RULE18
  assign {program_counter, thumb_bit, link_register} = {pc_ff, thumb_ff, link_ff};
  assign {handler_mode, active_exception_number, exec_state_it} = {handler_ff, exc_num_ff, it_ff};
  assign {control_bits, coproc_access_ctrl} = {control_ff, coproc_ff};
  assign {fp_default_status, auto_fp_save_enable} = {fp_dflt_ff, auto_save_ff};
  assign {lazy_fp_save_enable, lazy_save_pending} = {lazy_en_ff, lazy_act_ff};
  assign {excl_open, event_reg} = {excl_open_ff, event_ff};
endmodule : epr_core

// file: verif/epr_monitor.sv
/*
 * Port checks on epr_core: decisions, vector loads, reset values.
 * Assumes it is bound to epr_core and drives nothing.
 */
`timescale 1ns/1ps
module epr_monitor
  import epr_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Vector read port
  input wire logic vec_rd_req,
  input wire logic [31:0] vec_rd_addr,
  input wire logic vec_rd_ack,
  input wire logic [31:0] vec_rd_data,
  // Requests
  input wire logic sync_req,
  input wire logic [8:0] sync_num,
  input wire logic sync_enabled,
  input wire logic sync_from_breakpoint,
  input wire logic async_req,
  input wire logic [8:0] async_num,
  input wire logic async_enabled,
  input wire logic async_is_irq,
  // Decisions and state
  input wire logic take_valid,
  input wire logic [8:0] take_num,
  input wire logic take_escalated,
  input wire logic [8:0] take_ret_src,
  input wire logic pend_valid,
  input wire logic [8:0] pend_num,
  input wire logic signed [9:0] exec_priority,
  input wire logic [31:0] main_stack_pointer,
  input wire logic [31:0] program_counter,
  input wire logic thumb_bit,
  input wire logic [31:0] link_register
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_take;
    sync_req |=> take_valid && take_ret_src == $past(sync_num);
  endproperty
  a_take: assert property (p_take) else $error("bad decision");
  property p_num;
    take_valid |-> take_num == (take_escalated ? EXC_HARD_FAULT : take_ret_src);
  endproperty
  a_num: assert property (p_num) else $error("bad taken number");
  property p_hf;
    sync_req && exec_priority < PRI_ZERO |=> !take_escalated;
  endproperty
  a_hf: assert property (p_hf) else $error("escalated at fault level");
  property p_dis;
    sync_req && !sync_enabled && sync_num != EXC_SUPERVISOR_CALL
      && exec_priority >= PRI_ZERO |=> take_escalated;
  endproperty
  a_dis: assert property (p_dis) else $error("disabled fault kept");
  property p_dbg;
    sync_req && sync_enabled && sync_num == EXC_DEBUG_MONITOR
      && !sync_from_breakpoint |=> !take_escalated;
  endproperty
  a_dbg: assert property (p_dbg) else $error("debug fault escalated");
  property p_irq;
    async_req && async_is_irq |=> pend_valid == $past(async_enabled)
      && (!pend_valid || pend_num == $past(async_num));
  endproperty
  a_irq: assert property (p_irq) else $error("bad interrupt pend");
  property p_async;
    async_req && !async_is_irq |=> pend_valid
      && pend_num == ($past(async_enabled) ? $past(async_num) : EXC_HARD_FAULT);
  endproperty
  a_async: assert property (p_async) else $error("bad async fault");
  property p_rst;
    disable iff (1'b0) !hresetn ##1 !hresetn
      |-> exec_priority == PRI_BASE_LEVEL && link_register == LINK_RESET;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset value");
  property p_msp;
    vec_rd_req && vec_rd_ack && !vec_rd_addr[2]
      |=> main_stack_pointer == ($past(vec_rd_data) & SP_ALIGN_MASK);
  endproperty
  a_msp: assert property (p_msp) else $error("bad stack load");
  property p_pc;
    vec_rd_req && vec_rd_ack && vec_rd_addr[2]
      |=> program_counter == ($past(vec_rd_data) & PC_ALIGN_MASK)
      && {31'h0000_0000, thumb_bit} == ($past(vec_rd_data) & 32'h0000_0001);
  endproperty
  a_pc: assert property (p_pc) else $error("bad entry load");
endmodule : epr_monitor

bind epr_core epr_monitor u_mon (.*);

// file: verif/epr_vec_mem.sv
/*
 * Vector table memory at the far side of the vector read port.
 * Assumes the core holds its request until acknowledged.
 */
`timescale 1ns/1ps
module epr_vec_mem (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Vector read port
  input wire logic vec_rd_req,
  input wire logic [31:0] vec_rd_addr,
  output logic vec_rd_ack,
  output logic [31:0] vec_rd_data,
  // Table words and answer delay
  input wire logic [31:0] word0,
  input wire logic [31:0] word1,
  input wire logic [3:0] lat
);
  logic [3:0] wait_ff;
  logic hit;
  assign hit = vec_rd_req && !vec_rd_ack && (wait_ff >= lat);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_ff <= 4'h0;
      vec_rd_ack <= 1'b0;
      vec_rd_data <= 32'h0000_0000;
    end else begin
      vec_rd_ack <= hit;
      // Data toggles outside the answer cycle
      vec_rd_data <= hit ? (vec_rd_addr[2] ? word1 : word0) : ~vec_rd_data;
      wait_ff <= (vec_rd_req && !hit && !vec_rd_ack) ? wait_ff + 4'h1 : 4'h0;
    end
  end
endmodule : epr_vec_mem

// file: verif/testbench.sv
/*
 * Self-checking bench for epr_core: register tasks, request checks, resets.
 * Assumes epr_vec_mem answers vector reads and epr_monitor is bound.
 */
`timescale 1ns/1ps
module testbench;
  import epr_pkg::*;
  localparam logic [31:0] ZW = 32'h0000_0000;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = ZW, hwdata = ZW;
  logic exc_enter = 1'b0, exc_return = 1'b0, sync_req = 1'b0, sync_enabled = 1'b0;
  logic sync_from_breakpoint = 1'b0, async_req = 1'b0;
  logic async_enabled = 1'b0, async_is_irq = 1'b0;
  logic [8:0] exc_enter_num = 9'h000, exc_return_num = 9'h000;
  logic [8:0] sync_num = 9'h000, async_num = 9'h000;
  logic [31:0] word0 = 32'h2000_0107, word1 = 32'h0000_0201;
  logic [3:0] lat = 4'h0;
  logic [31:0] hrdata, vec_rd_addr, vec_rd_data, main_stack_pointer;
  logic [31:0] process_stack_pointer, program_counter, link_register;
  logic hreadyout, hresp, vec_rd_req, vec_rd_ack, take_valid, take_escalated;
  logic pend_valid, reset_done, thumb_bit, handler_mode, excl_open, event_reg;
  logic auto_fp_save_enable, lazy_fp_save_enable, lazy_save_pending;
  logic [8:0] take_num, take_ret_src, pend_num, active_exception_number;
  logic signed [9:0] exec_priority;
  logic [7:0] exec_state_it;
  logic [2:0] control_bits;
  logic [3:0] coproc_access_ctrl;
  logic [4:0] fp_default_status;
  int n_fail = 0;
  int compares = 0;
  int cycles = 0;

  epr_core u_dut (.hready(hreadyout), .event_clear(1'b0), .excl_mark(1'b0), .*);
  epr_vec_mem u_mem (.*);

  always #5 hclk = ~hclk;

  task automatic complete_run();
    $display("Counts: compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run

  // Ceiling far above the fewer than two hundred cycles the tests need
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      $display("MISMATCH at %0t: timeout", $time);
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, ZW, x);
    chk(x, e);
  endtask : rdc

  task automatic setpri(input logic [8:0] n, input logic [7:0] p);
    wr(OFS_PRI_SEL, {23'h00_0000, n});
    wr(OFS_PRI_DATA, {24'h00_0000, p});
  endtask : setpri

  task automatic evt(input logic r, input logic [8:0] n);
    exc_enter <= !r;
    exc_return <= r;
    exc_enter_num <= n;
    exc_return_num <= n;
    @(posedge hclk);
    exc_enter <= 1'b0;
    exc_return <= 1'b0;
    @(posedge hclk);
  endtask : evt

  task automatic epri(input logic [31:0] e);
    repeat (2) @(posedge hclk);
    chk(32'(exec_priority), e);
  endtask : epri

  task automatic sreq(input logic [8:0] n, input logic en, input logic bk, input logic esc);
    sync_req <= 1'b1;
    sync_num <= n;
    sync_enabled <= en;
    sync_from_breakpoint <= bk;
    @(posedge hclk);
    sync_req <= 1'b0;
    @(posedge hclk);
    chk({take_valid, take_escalated, take_num, take_ret_src},
        {1'b1, esc, esc ? EXC_HARD_FAULT : n, n});
  endtask : sreq

  task automatic areq(input logic [8:0] n, input logic en, input logic irq,
                      input logic v, input logic [8:0] e);
    async_req <= 1'b1;
    async_num <= n;
    async_enabled <= en;
    async_is_irq <= irq;
    @(posedge hclk);
    async_req <= 1'b0;
    @(posedge hclk);
    chk({pend_valid, v ? pend_num : 9'h000}, {v, e});
  endtask : areq

  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    wait (reset_done === 1'b1);
    @(posedge hclk);
    chk(main_stack_pointer, 32'h2000_0104);
    chk(process_stack_pointer & 32'h0000_0003, ZW);
    chk(program_counter, 32'h0000_0200);
    chk({31'h0000_0000, thumb_bit}, 32'h0000_0001);
    chk(link_register, LINK_RESET);
    chk({handler_mode, active_exception_number, exec_state_it}, ZW);
    chk({control_bits, coproc_access_ctrl, fp_default_status, auto_fp_save_enable,
         lazy_fp_save_enable, lazy_save_pending}, 32'h0000_0006);
    chk({excl_open, event_reg}, 32'h0000_0002);
    rdc(OFS_BASE_PRI, ZW);
    rdc(OFS_CFG_IRQ_MASK, ZW);
    rdc(OFS_FAULT_MASK, ZW);
    rdc(OFS_EXEC_PRI, 32'h0000_0100);
    $display("End of test: reset");
    wr(OFS_VECTOR_BASE, 32'hFFFF_FFFF);
    rdc(OFS_VECTOR_BASE, 32'hFFFF_FF80);
    wr(8'h40, 32'hFFFF_FFFF);
    rdc(8'h40, ZW);
    $display("End of test: registers");
    wr(OFS_GROUP_SPLIT, 32'h0000_0002);
    setpri(9'h004, 8'h30);
    setpri(9'h005, 8'h47);
    setpri(9'h006, 8'h48);
    setpri(9'h00B, 8'h10);
    setpri(9'h00C, 8'h48);
    evt(1'b0, 9'h005);
    epri(32'h0000_0040);
    evt(1'b0, 9'h006);
    epri(32'h0000_0040);
    rdc(OFS_EXEC_PRI, 32'h0000_0040);
    wr(OFS_BASE_PRI, 32'h0000_0023);
    epri(32'h0000_0020);
    wr(OFS_BASE_PRI, 32'h0000_005F);
    epri(32'h0000_0040);
    wr(OFS_BASE_PRI, ZW);
    $display("End of test: priority");
    sreq(9'h006, 1'b1, 1'b0, 1'b1);
    sreq(9'h004, 1'b1, 1'b0, 1'b0);
    sreq(9'h004, 1'b0, 1'b0, 1'b1);
    sreq(9'h00C, 1'b1, 1'b0, 1'b0);
    sreq(9'h00C, 1'b1, 1'b1, 1'b1);
    sreq(9'h00B, 1'b0, 1'b0, 1'b0);
    wr(OFS_CFG_IRQ_MASK, 32'h0000_0001);
    wr(OFS_BASE_PRI, 32'h0000_0023);
    epri(ZW);
    sreq(9'h00B, 1'b1, 1'b0, 1'b1);
    wr(OFS_FAULT_MASK, 32'h0000_0001);
    epri(32'hFFFF_FFFF);
    sreq(9'h006, 1'b1, 1'b0, 1'b0);
    evt(1'b1, 9'h005);
    epri(ZW);
    rdc(OFS_FAULT_MASK, ZW);
    wr(OFS_CFG_IRQ_MASK, ZW);
    epri(32'h0000_0020);
    wr(OFS_BASE_PRI, ZW);
    epri(32'h0000_0048);
    evt(1'b1, 9'h006);
    epri(32'h0000_0100);
    for (int i = 2; i < 4; i++) begin
      evt(1'b0, 9'(i));
      epri(32'(i - 4));
      evt(1'b1, 9'(i));
      epri(32'h0000_0100);
    end
    $display("End of test: escalation");
    areq(9'h014, 1'b1, 1'b1, 1'b1, 9'h014);
    areq(9'h015, 1'b0, 1'b1, 1'b0, 9'h000);
    areq(9'h005, 1'b0, 1'b0, 1'b1, EXC_HARD_FAULT);
    areq(9'h005, 1'b1, 1'b0, 1'b1, 9'h005);
    $display("End of test: async");
    evt(1'b0, 9'h005);
    wr(OFS_BASE_PRI, 32'h0000_0023);
    word0 <= 32'h3000_000B;
    word1 <= 32'h1000_0400;
    lat <= 4'h3;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    wait (reset_done === 1'b1);
    @(posedge hclk);
    chk(main_stack_pointer, 32'h3000_0008);
    chk(program_counter, 32'h1000_0400);
    chk({31'h0000_0000, thumb_bit}, ZW);
    chk(32'(exec_priority), 32'h0000_0100);
    rdc(OFS_BASE_PRI, ZW);
    rdc(OFS_VECTOR_BASE, ZW);
    $display("End of test: second reset");
    complete_run();
  end
endmodule : testbench
